// File: src/decoder_ctrl_defines.vh
// register offsets, field positions, reset values and encodings of the decoder control bank
`ifndef DECODER_CTRL_DEFINES_VH
`define DECODER_CTRL_DEFINES_VH

// ----------------------------------------------------------------
// register offsets (serial management sub-addresses)
// ----------------------------------------------------------------
`define ADDR_DECODER_CONTROL_ONE     8'h03
`define ADDR_DECODER_CONTROL_TWO     8'h04
`define ADDR_AMPLIFIER_GAIN_SETTING  8'h05

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_DECODER_CONTROL_ONE      8'h00
`define RST_DECODER_CONTROL_TWO      8'h00
`define RST_AMPLIFIER_GAIN_SETTING   8'h15
`define RST_GAIN_FIELD               7'h15

// ----------------------------------------------------------------
// control one fields
// ----------------------------------------------------------------
`define C1_SPLIT_BIT                 0
`define C1_KILL_LSB                  1
`define C1_KILL_MSB                  2
`define C1_CORING_LSB                3
`define C1_CORING_MSB                4
`define C1_SPEED_BIT                 5
`define C1_VPIN_BIT                  6

// ----------------------------------------------------------------
// control two fields
// ----------------------------------------------------------------
`define C2_AGC_BIT                   0
`define C2_ACC_BIT                   1
`define C2_KILL_DIS_BIT              2
`define C2_FRAME_LSB                 3
`define C2_FRAME_MSB                 4
`define C2_PARITY_BIT                5
`define C2_NOSIG_BIT                 6
`define C2_PIVOT_BIT                 7

// ----------------------------------------------------------------
// gain field and encodings
// ----------------------------------------------------------------
`define GAIN_MSB                     6
`define KILL_EITHER                  2'h0
`define KILL_PLL                     2'h1
`define KILL_BURST                   2'h2
`define CORING_2LSB                  2'h0
`define CORING_3LSB                  2'h1
`define CORING_4LSB                  2'h2
`define CORING_OFF                   2'h3
`define FRAME_DIV1                   2'h0
`define FRAME_DIV2                   2'h1
`define FRAME_DIV4                   2'h2
`define OIF_CAM_PLAIN                2'h0
`define OIF_CAM_TRS                  2'h1
`define CORING_BAND_2                3'h2
`define CORING_BAND_3                3'h3
`define CORING_BAND_4                3'h4
`define PIVOT_GREY                   8'h80
`define PIVOT_BLACK                  8'h10

`endif

// File: src/video_decoder_control_regs.v
// control register bank of the composite video decoder and the control decodes it feeds
// Functional notes
// - split bit 0: primary filter for both; 1: luma primary, chroma two-dimensional
// - kill condition 01 pll unlock, 10 weak burst, 00 either, 11 reserved
// - coring 00 +-2, 01 +-3, 10 +-4 lsb, 11 coring off
// - gain speed bit 0 quick, 1 slow for sync and peak loops
// - vertical pin carries vsync/valid area when 0, field id when 1
// - camera interface mode always puts valid area on the vertical pin
// - automatic gain enable and chroma level loop enable, active high
// - colour kill disable bit set means colour kill never applied
// - frame rate field divides rate by 1, 2, 4; code 11 reserved
// - field parity bit selects odd (0) or even (1) decoded field
// - no-signal pin high on h+v loss (0) or v loss only (1)
// - contrast pivot at level 128 when 0, level 16 when 1
// - seven-bit gain sets amplifier gain in manual mode
// - with automatic gain on, reads return the loop's gain
// - with automatic gain on, writes are stored but do not reach amplifier
// - with automatic gain off, written gain drives amplifier and reads back
// - output interface codes 00 and 01 are camera interface mode
`timescale 1ns/100ps
`include "decoder_ctrl_defines.vh"

module video_decoder_control_regs (
   input  wire       clk_i,
   input  wire       rst_i,
   input  wire       reg_wr_i,
   input  wire       reg_rd_i,
   input  wire [7:0] reg_addr_i,
   input  wire [7:0] reg_wdata_i,
   output reg  [7:0] reg_rdata_o,
   input  wire [1:0] output_interface_select_i,
   input  wire [6:0] agc_loop_gain_i,
   input  wire       pll_unlock_i,
   input  wire       burst_low_i,
   input  wire       hsync_lost_i,
   input  wire       vsync_lost_i,
   input  wire       vsync_valid_i,
   input  wire       valid_area_signal_i,
   input  wire       field_id_i,
   output reg        luma_chroma_split_select_o,
   output reg        chroma_2d_filter_o,
   output reg  [1:0] colour_kill_condition_o,
   output reg        colour_kill_o,
   output reg  [1:0] gain_loop_coring_level_o,
   output reg  [2:0] coring_band_lsb_o,
   output reg        gain_loop_speed_o,
   output reg        vertical_pin_o,
   output reg        automatic_gain_enable_o,
   output reg        chroma_level_loop_enable_o,
   output reg        colour_kill_disable_o,
   output reg  [1:0] frame_rate_reduce_o,
   output reg  [2:0] frame_rate_div_o,
   output reg        field_parity_select_o,
   output reg        no_signal_pin_o,
   output reg        free_run_o,
   output reg        contrast_pivot_select_o,
   output reg  [7:0] contrast_pivot_level_o,
   output reg  [6:0] input_amplifier_gain_o
);

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   function is_camera_mode;
      input [1:0] output_interface_select;
      begin
         is_camera_mode = (output_interface_select == `OIF_CAM_PLAIN) || (output_interface_select == `OIF_CAM_TRS);
      end
   endfunction

   function is_addr;
      input [7:0] addr;
      input [7:0] offset;
      begin
         is_addr = (addr == offset);
      end
   endfunction

   // ----------------------------------------------------------------
   // register storage
   // ----------------------------------------------------------------
   reg  [7:0] control_one_q;
   reg  [7:0] control_two_q;
   reg  [7:0] gain_setting_q;
   wire       wr_one;
   wire       wr_two;
   wire       wr_gain;
   wire       split_sel;
   wire [1:0] kill_sel;
   wire [1:0] coring_sel;
   wire       speed_sel;
   wire       vpin_sel;
   wire       agc_on;
   wire       acc_on;
   wire       kill_off;
   wire [1:0] frame_sel;
   wire       parity_sel;
   wire       nosig_sel;
   wire       pivot_sel;
   wire [7:0] gain_view;
   wire [6:0] gain_field;
   wire       sync_lost_d;
   reg  [7:0] rdata_d;
   reg        kill_d;
   reg  [2:0] band_d;
   reg  [2:0] div_d;

   // ----------------------------------------------------------------
   // write enables
   // ----------------------------------------------------------------
   assign wr_one  = reg_wr_i & is_addr(reg_addr_i, `ADDR_DECODER_CONTROL_ONE);
   assign wr_two  = reg_wr_i & is_addr(reg_addr_i, `ADDR_DECODER_CONTROL_TWO);
   assign wr_gain = reg_wr_i & is_addr(reg_addr_i, `ADDR_AMPLIFIER_GAIN_SETTING);

   // ----------------------------------------------------------------
   // register write
   // ----------------------------------------------------------------
   // reserved bits are kept as written so software reads back what it wrote, except gain bit 7, which reads 0 while agc is on
   always @(posedge clk_i) begin
      if (rst_i) begin
         control_one_q <= `RST_DECODER_CONTROL_ONE;
      end else if (wr_one) begin
         control_one_q <= reg_wdata_i;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         control_two_q <= `RST_DECODER_CONTROL_TWO;
      end else if (wr_two) begin
         control_two_q <= reg_wdata_i;
      end
   end

   // gain writes are taken even under agc; they reach the amplifier once agc is off
   always @(posedge clk_i) begin
      if (rst_i) begin
         gain_setting_q <= `RST_AMPLIFIER_GAIN_SETTING;
      end else if (wr_gain) begin
         gain_setting_q <= reg_wdata_i;
      end
   end

   // ----------------------------------------------------------------
   // register fields
   // ----------------------------------------------------------------
   assign split_sel  = control_one_q[`C1_SPLIT_BIT];
   assign kill_sel   = control_one_q[`C1_KILL_MSB:`C1_KILL_LSB];
   assign coring_sel = control_one_q[`C1_CORING_MSB:`C1_CORING_LSB];
   assign speed_sel  = control_one_q[`C1_SPEED_BIT];
   assign vpin_sel   = control_one_q[`C1_VPIN_BIT];
   assign agc_on     = control_two_q[`C2_AGC_BIT];
   assign acc_on     = control_two_q[`C2_ACC_BIT];
   assign kill_off   = control_two_q[`C2_KILL_DIS_BIT];
   assign frame_sel  = control_two_q[`C2_FRAME_MSB:`C2_FRAME_LSB];
   assign parity_sel = control_two_q[`C2_PARITY_BIT];
   assign nosig_sel  = control_two_q[`C2_NOSIG_BIT];
   assign pivot_sel  = control_two_q[`C2_PIVOT_BIT];
   // the written value stays held under agc so it is back in force the moment agc drops
   assign gain_view  = agc_on ? {1'b0, agc_loop_gain_i} : gain_setting_q;
   assign gain_field = gain_view[`GAIN_MSB:0];

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------
   always @* begin
      rdata_d = 8'h00; // unmapped sub-addresses read as zero
      if (is_addr(reg_addr_i, `ADDR_DECODER_CONTROL_ONE)) begin
         rdata_d = control_one_q;
      end
      if (is_addr(reg_addr_i, `ADDR_DECODER_CONTROL_TWO)) begin
         rdata_d = control_two_q;
      end
      if (is_addr(reg_addr_i, `ADDR_AMPLIFIER_GAIN_SETTING)) begin
         rdata_d = gain_view;
      end
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_d;
      end
   end

   // ----------------------------------------------------------------
   // control decodes
   // ----------------------------------------------------------------
   always @* begin
      case (kill_sel)
         `KILL_EITHER: kill_d = pll_unlock_i | burst_low_i;
         `KILL_PLL:    kill_d = pll_unlock_i;
         `KILL_BURST:  kill_d = burst_low_i;
         default:      kill_d = 1'b0; // reserved code: no kill
      endcase
      case (coring_sel)
         `CORING_2LSB: band_d = `CORING_BAND_2;
         `CORING_3LSB: band_d = `CORING_BAND_3;
         `CORING_4LSB: band_d = `CORING_BAND_4;
         default:      band_d = 3'h0; // coring off
      endcase
      case (frame_sel)
         `FRAME_DIV1: div_d = 3'h1;
         `FRAME_DIV2: div_d = 3'h2;
         `FRAME_DIV4: div_d = 3'h4;
         default:     div_d = 3'h1; // reserved code: full rate
      endcase
   end

   // ----------------------------------------------------------------
   // separation filter and colour kill outputs
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         luma_chroma_split_select_o <= 1'b0;
         chroma_2d_filter_o         <= 1'b0;
         colour_kill_condition_o    <= 2'h0;
         colour_kill_o              <= 1'b0;
         colour_kill_disable_o      <= 1'b0;
      end else begin
         luma_chroma_split_select_o <= split_sel;
         chroma_2d_filter_o         <= split_sel;
         colour_kill_condition_o    <= kill_sel;
         // the disable bit overrides every condition code
         colour_kill_o              <= kill_d & ~kill_off;
         colour_kill_disable_o      <= kill_off;
      end
   end

   // ----------------------------------------------------------------
   // gain loop outputs
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         gain_loop_coring_level_o   <= 2'h0;
         coring_band_lsb_o          <= `CORING_BAND_2;
         gain_loop_speed_o          <= 1'b0;
         automatic_gain_enable_o    <= 1'b0;
         chroma_level_loop_enable_o <= 1'b0;
         input_amplifier_gain_o     <= `RST_GAIN_FIELD;
      end else begin
         gain_loop_coring_level_o   <= coring_sel;
         coring_band_lsb_o          <= band_d;
         gain_loop_speed_o          <= speed_sel;
         automatic_gain_enable_o    <= agc_on;
         chroma_level_loop_enable_o <= acc_on;
         input_amplifier_gain_o     <= gain_field;
      end
   end

   // ----------------------------------------------------------------
   // shared vertical pin
   // ----------------------------------------------------------------
   // camera mode is tested first so the content bit can never override it
   always @(posedge clk_i) begin
      if (rst_i) begin
         vertical_pin_o <= 1'b0;
      end else if (is_camera_mode(output_interface_select_i)) begin
         vertical_pin_o <= valid_area_signal_i;
      end else if (vpin_sel) begin
         vertical_pin_o <= field_id_i;
      end else begin
         vertical_pin_o <= vsync_valid_i;
      end
   end

   // ----------------------------------------------------------------
   // frame rate and field outputs
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         frame_rate_reduce_o   <= 2'h0;
         frame_rate_div_o      <= 3'h1;
         field_parity_select_o <= 1'b0;
      end else begin
         frame_rate_reduce_o   <= frame_sel;
         frame_rate_div_o      <= div_d;
         field_parity_select_o <= parity_sel;
      end
   end

   // ----------------------------------------------------------------
   // no-signal pin and free-running mode
   // ----------------------------------------------------------------
   assign sync_lost_d = nosig_sel ? vsync_lost_i : (hsync_lost_i & vsync_lost_i);

   always @(posedge clk_i) begin
      if (rst_i) begin
         no_signal_pin_o <= 1'b0;
         free_run_o      <= 1'b0;
      end else begin
         no_signal_pin_o <= sync_lost_d;
         free_run_o      <= sync_lost_d;
      end
   end

   // ----------------------------------------------------------------
   // contrast pivot
   // ----------------------------------------------------------------
   always @(posedge clk_i) begin
      if (rst_i) begin
         contrast_pivot_select_o <= 1'b0;
         contrast_pivot_level_o  <= `PIVOT_GREY;
      end else begin
         contrast_pivot_select_o <= pivot_sel;
         contrast_pivot_level_o  <= pivot_sel ? `PIVOT_BLACK : `PIVOT_GREY;
      end
   end

endmodule // video_decoder_control_regs

// File: testbench/tb_video_decoder_control_regs.sv
// self-checking bench for the decoder control register bank
`timescale 1ns/100ps
module tb_video_decoder_control_regs;
   logic       clk_i, rst_i, reg_wr_i, reg_rd_i, pll_unlock_i, burst_low_i, hsync_lost_i, vsync_lost_i, exp_b;
   logic       vsync_valid_i, valid_area_signal_i, field_id_i, luma_chroma_split_select_o, chroma_2d_filter_o;
   logic       colour_kill_o, gain_loop_speed_o, vertical_pin_o, automatic_gain_enable_o, chroma_level_loop_enable_o;
   logic       colour_kill_disable_o, field_parity_select_o, no_signal_pin_o, free_run_o, contrast_pivot_select_o;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, contrast_pivot_level_o, rd;
   logic [6:0] agc_loop_gain_i, input_amplifier_gain_o;
   logic [2:0] coring_band_lsb_o, frame_rate_div_o;
   logic [1:0] output_interface_select_i, colour_kill_condition_o, gain_loop_coring_level_o, frame_rate_reduce_o;
   int         failures, n_compared;
   typedef struct packed {logic [7:0] c1, c2, g, piv; logic [2:0] band, div;} row_t;
   // reserved codes and bit 7 rows show stored-as-written reads
   row_t rows [4] = '{'{8'h00, 8'h00, 8'h7f, 8'h80, 3'h2, 3'h1}, '{8'h09, 8'h8a, 8'h00, 8'h10, 3'h3, 3'h2},
                      '{8'h52, 8'h30, 8'h2c, 8'h80, 3'h4, 3'h4}, '{8'hbc, 8'h9c, 8'h80, 8'h10, 3'h0, 3'h1}};
   video_decoder_control_regs i_dut (.*);
   initial begin
      clk_i = 1'b0;
      forever #2 clk_i = ~clk_i;
   end
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      reg_wr_i <= 1'b1;
      reg_addr_i <= a;
      reg_wdata_i <= d;
      @(posedge clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk_i);
      reg_rd_i <= 1'b1;
      reg_addr_i <= a;
      @(posedge clk_i);
      reg_rd_i <= 1'b0;
      #1 rd = reg_rdata_o;
   endtask
   // decoded outputs land one edge after the write edge
   task automatic settle;
      repeat (3) @(posedge clk_i);
      #1;
   endtask
   task automatic end_sim;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      {reg_wr_i, reg_rd_i, pll_unlock_i, burst_low_i, hsync_lost_i, vsync_lost_i} = 6'h0;
      {vsync_valid_i, valid_area_signal_i, field_id_i, reg_addr_i, reg_wdata_i, agc_loop_gain_i} = 26'h0;
      output_interface_select_i = 2'h3;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      foreach (rows[i]) begin
         wr(8'h03, rows[i].c1);
         wr(8'h04, rows[i].c2);
         wr(8'h05, rows[i].g);
         settle;
         chk("coring band", rows[i].band, coring_band_lsb_o);
         chk("frame divider", rows[i].div, frame_rate_div_o);
         chk("contrast pivot", rows[i].piv, contrast_pivot_level_o);
         chk("chroma filter", rows[i].c1[0], chroma_2d_filter_o);
         chk("gain speed", rows[i].c1[5], gain_loop_speed_o);
         chk("field parity", rows[i].c2[5], field_parity_select_o);
         chk("manual gain", rows[i].g[6:0], input_amplifier_gain_o);
         chk("split select", rows[i].c1[0], luma_chroma_split_select_o);
         chk("kill condition", rows[i].c1[2:1], colour_kill_condition_o);
         chk("coring level", rows[i].c1[4:3], gain_loop_coring_level_o);
         chk("frame code", rows[i].c2[4:3], frame_rate_reduce_o);
         chk("pivot select", rows[i].c2[7], contrast_pivot_select_o);
         chk("kill disable", rows[i].c2[2], colour_kill_disable_o);
         chk("chroma loop row", rows[i].c2[1], chroma_level_loop_enable_o);
         chk("agc enable row", rows[i].c2[0], automatic_gain_enable_o);
         rd_reg(8'h03);
         chk("control one", rows[i].c1, rd);
         rd_reg(8'h04);
         chk("control two", rows[i].c2, rd);
         rd_reg(8'h05);
         chk("gain read", rows[i].g, rd);
      end
      $display("register table test done");
      for (int i = 0; i < 32; i++) begin
         wr(8'h03, {5'h0, i[1:0], 1'b0});
         wr(8'h04, {5'h0, i[4], 2'h0});
         pll_unlock_i <= i[2];
         burst_low_i <= i[3];
         settle;
         exp_b = !i[4] && (i[1:0] == 0 ? |i[3:2] : i[1:0] == 1 ? i[2] : i[1:0] == 2 ? i[3] : 1'b0);
         chk("colour kill", exp_b, colour_kill_o);
         wr(8'h03, {1'b0, i[2], 6'h0});
         output_interface_select_i <= i[1:0];
         valid_area_signal_i <= i[3];
         vsync_valid_i <= !i[3];
         field_id_i <= i[4];
         wr(8'h04, {1'b0, i[0], 6'h0});
         hsync_lost_i <= i[1];
         vsync_lost_i <= i[3];
         settle;
         exp_b = i[1:0] < 2 ? i[3] : i[2] ? i[4] : !i[3];
         chk("vertical pin", exp_b, vertical_pin_o);
         exp_b = i[0] ? i[3] : i[1] && i[3];
         chk("no signal pin", exp_b, no_signal_pin_o);
         chk("free run", exp_b, free_run_o);
      end
      $display("decode test done");
      agc_loop_gain_i <= 7'h2a;
      wr(8'h05, 8'h33);
      wr(8'h04, 8'h03);
      settle;
      chk("agc enable", 8'h01, automatic_gain_enable_o);
      chk("chroma loop", 8'h01, chroma_level_loop_enable_o);
      rd_reg(8'h05);
      chk("agc gain read", 8'h2a, rd);
      wr(8'h05, 8'h44);
      settle;
      chk("agc gain out", 8'h2a, input_amplifier_gain_o);
      rd_reg(8'h05);
      chk("agc read after write", 8'h2a, rd);
      wr(8'h04, 8'h00);
      settle;
      chk("manual gain out", 8'h44, input_amplifier_gain_o);
      rd_reg(8'h05);
      chk("manual gain read", 8'h44, rd);
      wr(8'h02, 8'h5a);
      rd_reg(8'h02);
      chk("unmapped read", 8'h00, rd);
      $display("gain and unmapped test done");
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      for (int i = 0; i < 3; i++) begin
         rd_reg(8'h03 + i[7:0]);
         chk("reset value", i == 2 ? 8'h15 : 8'h00, rd);
      end
      chk("reset gain out", 8'h15, input_amplifier_gain_o);
      $display("reset test done");
      end_sim;
   end
endmodule // tb_video_decoder_control_regs

// File: testbench/video_decoder_control_regs_assertions.sv
// port-level checks of the decoder control register bank
`timescale 1ns/100ps
module video_decoder_control_regs_assertions (
   input wire       clk_i, rst_i, reg_wr_i, reg_rd_i, pll_unlock_i, burst_low_i, hsync_lost_i, vsync_lost_i,
   input wire       valid_area_signal_i, luma_chroma_split_select_o, chroma_2d_filter_o, colour_kill_o,
   input wire       automatic_gain_enable_o, chroma_level_loop_enable_o, colour_kill_disable_o, vertical_pin_o,
   input wire       no_signal_pin_o, free_run_o, contrast_pivot_select_o,
   input wire [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, contrast_pivot_level_o,
   input wire [6:0] agc_loop_gain_i, input_amplifier_gain_o,
   input wire [2:0] coring_band_lsb_o, frame_rate_div_o,
   input wire [1:0] output_interface_select_i, colour_kill_condition_o, gain_loop_coring_level_o, frame_rate_reduce_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ----------------------------------------------------------------
   // sequences
   // ----------------------------------------------------------------
   sequence ctl2_write_s;
      reg_wr_i && reg_addr_i == 8'h04 ##1 !(reg_wr_i && reg_addr_i == 8'h04);
   endsequence
   sequence gain_read_s;
      reg_rd_i && reg_addr_i == 8'h05 ##1 automatic_gain_enable_o;
   endsequence
   sequence ctl1_write_s;
      reg_wr_i && reg_addr_i == 8'h03 ##1 !(reg_wr_i && reg_addr_i == 8'h03);
   endsequence
   sequence gain_write_s;
      reg_wr_i && reg_addr_i == 8'h05 ##2 !automatic_gain_enable_o;
   endsequence
   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   split_copy_a: assert property (ctl1_write_s |-> ##1 chroma_2d_filter_o == $past(reg_wdata_i[0], 2)
      && luma_chroma_split_select_o == $past(reg_wdata_i[0], 2)) else $error("split select does not follow write");
   manual_gain_a: assert property (gain_write_s |-> input_amplifier_gain_o == $past(reg_wdata_i[6:0], 2))
      else $error("manual gain does not reach amplifier");
   kill_cond_a: assert property (!$past(rst_i) |-> colour_kill_o == (!colour_kill_disable_o &&
      (colour_kill_condition_o == 2'h0 ? $past(pll_unlock_i || burst_low_i) : colour_kill_condition_o == 2'h1 ?
      $past(pll_unlock_i) : colour_kill_condition_o == 2'h2 ? $past(burst_low_i) : 1'b0)))
      else $error("colour kill output wrong");
   coring_map_a: assert property (coring_band_lsb_o == (gain_loop_coring_level_o == 2'h3 ? 3'h0 :
      {1'b0, gain_loop_coring_level_o} + 3'h2)) else $error("coring band wrong");
   frame_div_a: assert property (frame_rate_div_o == (frame_rate_reduce_o == 2'h1 ? 3'h2 :
      frame_rate_reduce_o == 2'h2 ? 3'h4 : 3'h1)) else $error("frame divider wrong");
   pivot_level_a: assert property (contrast_pivot_level_o == (contrast_pivot_select_o ? 8'h10 : 8'h80))
      else $error("contrast pivot wrong");
   camera_pin_a: assert property (!$past(rst_i) && $past(output_interface_select_i) < 2'h2
      |-> vertical_pin_o == $past(valid_area_signal_i)) else $error("camera mode vertical pin wrong");
   no_signal_a: assert property (!$past(rst_i) |-> free_run_o == no_signal_pin_o && (no_signal_pin_o ?
      $past(vsync_lost_i) : !$past(hsync_lost_i && vsync_lost_i))) else $error("no signal pin wrong");
   agc_gain_out_a: assert property (!$past(rst_i) && automatic_gain_enable_o
      |-> input_amplifier_gain_o == $past(agc_loop_gain_i)) else $error("amplifier ignores loop gain");
   agc_gain_read_a: assert property (gain_read_s |-> reg_rdata_o == {1'b0, $past(agc_loop_gain_i)})
      else $error("gain read under automatic gain wrong");
   loop_enables_a: assert property (ctl2_write_s |-> ##1 automatic_gain_enable_o == $past(reg_wdata_i[0], 2)
      && chroma_level_loop_enable_o == $past(reg_wdata_i[1], 2) && colour_kill_disable_o == $past(reg_wdata_i[2], 2))
      else $error("loop enables do not follow write");
endmodule // video_decoder_control_regs_assertions
bind video_decoder_control_regs video_decoder_control_regs_assertions i_chk (.*);
